/* File: rtl/mpspi_pkg.sv */
package mpspi_pkg;
    // Frame layout: command or status byte on top, 16 data bits below.
    localparam int FRAME_BITS = 24;
    localparam int DATA_W = 16;
    localparam int CMD_W = 8;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] FRAME_COUNT = 6'h18;
    localparam int OP_HI = 23;
    localparam int OP_LO = 22;
    localparam int ADDR_HI = 21;
    localparam int ADDR_LO = 16;
    localparam logic [FRAME_BITS-1:0] STUCK_FRAME = 24'hFFFFFF;

    // Operation codes.
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_RDCLR = 2'h2;
    localparam logic [1:0] OP_INFO = 2'h3;

    // Register and identification addresses.
    localparam logic [5:0] ADDR_CONTROL = 6'h00;
    localparam logic [5:0] ADDR_STATUS = 6'h10;
    localparam logic [5:0] ADDR_CONFIG = 6'h3F;
    localparam logic [5:0] ADDR_ID0 = 6'h3A;
    localparam logic [5:0] ADDR_ID1 = 6'h3B;
    localparam logic [5:0] ADDR_ID2 = 6'h3C;
    localparam logic [5:0] ADDR_ID3 = 6'h3D;
    localparam logic [5:0] ADDR_FRAME_ID = 6'h3E;

    // Control register fields and writable bits.
    localparam int CTL_HS1 = 9;
    localparam int CTL_LS1 = 8;
    localparam int CTL_HS2 = 7;
    localparam int CTL_LS2 = 6;
    localparam int CTL_FWH = 4;
    localparam int CTL_FWA = 3;
    localparam int CTL_OVR = 2;
    localparam int CTL_UVR = 1;
    localparam int CTL_MODE = 0;
    localparam logic [DATA_W-1:0] CONTROL_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] CONTROL_MASK = 16'h03DF;
    localparam logic [DATA_W-1:0] CONFIG_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] CONFIG_MASK = 16'hFFF8;

    // Global status byte bit positions within the byte.
    localparam int GS_FLT = 7;
    localparam int GS_TF = 6;
    localparam int GS_RESET_INDICATOR = 5;
    localparam int GS_TSD = 4;
    localparam int GS_UOV = 2;
    localparam int GS_NOT_READY_FLAG = 0;
    localparam logic [CMD_W-1:0] STATUS_RESET = 8'h81;

    // Host timing: system clock period, select high time, clock half period.
    localparam int CLK_NS = 5;
    localparam int CSN_HIGH_NS = 10000;
    localparam int CSN_HIGH_CYC = (CSN_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCLK_HALF_NS = 60;
    localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_NS;
    localparam int GAP_W = 12;
    localparam int HALF_W = 8;
endpackage : mpspi_pkg

/* File: rtl/mpspi_if.sv */
`timescale 1ns/10ps
interface mpspi_if;
    logic serial_clk;
    logic select_n;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe_n;

    modport dev (
        input serial_clk,
        input select_n,
        input serial_in,
        output serial_out,
        output serial_out_oe_n
    );

    modport host (
        output serial_clk,
        output select_n,
        output serial_in,
        input serial_out,
        input serial_out_oe_n
    );
endinterface : mpspi_if

/* File: rtl/mpspi_device.sv */
`timescale 1ns/10ps
module mpspi_device #(
    parameter logic [7:0] ID_HEADER = 8'h5A, // Arbitrary value.
    parameter logic [7:0] ID_PRODUCT = 8'h11, // Arbitrary value.
    parameter logic [7:0] ID_VERSION = 8'h01, // Arbitrary value.
    parameter logic [7:0] ID_CATEGORY = 8'h02, // Arbitrary value.
    parameter logic [7:0] ID_FRAME = 8'h18
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    mpspi_if.dev link,
    input wire logic i_thermal_event,
    input wire logic i_supply_fault,
    input wire logic i_not_ready,
    input wire logic [mpspi_pkg::DATA_W-1:0] i_diag_event,
    output logic [mpspi_pkg::DATA_W-1:0] o_bridge_control,
    output logic [mpspi_pkg::DATA_W-1:0] o_general_configuration,
    output logic o_standby,
    output logic o_frame_done
);
    import mpspi_pkg::*;

    typedef enum logic [1:0] {
        DEV_IDLE = 2'b01,
        DEV_FRAME = 2'b10
    } mpspi_dev_e;

    mpspi_dev_e state_q;
    logic [2:0] sync1_q, sync2_q;
    logic [1:0] prev_q;
    logic [FRAME_BITS-1:0] rx_q, tx_q;
    logic [CNT_W-1:0] cnt_q;
    logic [DATA_W-1:0] ctrl_q, cfg_q, diag_q;
    logic [1:0] sel_op_q;
    logic [5:0] sel_addr_q;
    logic tf_q, reset_indicator_q, tsd_q, uov_q, not_ready_flag_q;
    logic sout_q, sout_oe_n_q, standby_q, done_q;
    logic sclk_s, csn_s, sin_s;
    logic sclk_rise, sclk_fall, csn_fall, csn_rise;
    logic frame_end, frame_ok, frame_bad, stuck, exec;
    logic [1:0] op;
    logic [5:0] addr;
    logic global_fault_flag, rdclr_hit;
    logic [CMD_W-1:0] status_byte;
    logic [DATA_W-1:0] readback;

    // All three link input pins are asynchronous to the system clock, so each passes two flops.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_q <= 3'h4;
            sync2_q <= 3'h4;
            prev_q <= 2'h2; // Idle levels, so no false edge follows reset.
        end else begin
            sync1_q <= {link.select_n, link.serial_clk, link.serial_in};
            sync2_q <= sync1_q;
            prev_q <= sync2_q[2:1];
        end
    end

    // Edge detection looks only at the second stage and its delayed copy.
    assign csn_s = sync2_q[2];
    assign sclk_s = sync2_q[1];
    assign sin_s = sync2_q[0];
    assign sclk_rise = sclk_s & ~prev_q[0] & (state_q == DEV_FRAME);
    assign sclk_fall = ~sclk_s & prev_q[0] & (state_q == DEV_FRAME);
    assign csn_fall = prev_q[1] & ~csn_s;
    assign csn_rise = ~prev_q[1] & csn_s;
    assign frame_end = csn_rise & (state_q == DEV_FRAME);

    // Length check at the closing edge of select.
    assign frame_ok = frame_end & (cnt_q == FRAME_COUNT);
    assign frame_bad = frame_end & (cnt_q != FRAME_COUNT) & (cnt_q != '0);
    assign stuck = frame_ok & (rx_q == STUCK_FRAME);
    assign exec = frame_ok & ~stuck;
    assign op = rx_q[OP_HI:OP_LO];
    assign addr = rx_q[ADDR_HI:ADDR_LO];
    assign rdclr_hit = frame_ok & (sel_op_q == OP_RDCLR) & (sel_addr_q == ADDR_STATUS);

    // Fault flag; a cleared reset indicator counts as a failure.
    assign global_fault_flag = tf_q | ~reset_indicator_q | tsd_q | uov_q | not_ready_flag_q | (|diag_q);
    always_comb begin
        status_byte = '0;
        status_byte[GS_FLT] = global_fault_flag;
        status_byte[GS_TF] = tf_q;
        status_byte[GS_RESET_INDICATOR] = reset_indicator_q;
        status_byte[GS_TSD] = tsd_q;
        status_byte[GS_UOV] = uov_q;
        status_byte[GS_NOT_READY_FLAG] = not_ready_flag_q;
    end

    // The data half returns what the previous valid frame selected, since the
    // address is still arriving when the shifter has to be loaded.
    always_comb begin
        readback = '0;
        if (sel_op_q == OP_INFO) begin
            case (sel_addr_q)
                ADDR_ID0: readback = {8'h00, ID_HEADER};
                ADDR_ID1: readback = {8'h00, ID_PRODUCT};
                ADDR_ID2: readback = {8'h00, ID_VERSION};
                ADDR_ID3: readback = {8'h00, ID_CATEGORY};
                ADDR_FRAME_ID: readback = {8'h00, ID_FRAME};
                default: readback = '0;
            endcase
        end else begin
            case (sel_addr_q)
                ADDR_CONTROL: readback = ctrl_q;
                ADDR_STATUS: readback = diag_q;
                ADDR_CONFIG: readback = cfg_q;
                default: readback = '0;
            endcase
        end
    end

    // Frame state: opened by select falling, closed by it rising.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= DEV_IDLE;
        end else begin
            case (state_q)
                DEV_IDLE: if (csn_fall) state_q <= DEV_FRAME;
                DEV_FRAME: if (csn_rise) state_q <= DEV_IDLE;
                default: state_q <= DEV_IDLE;
            endcase
        end
    end

    // Receive and transmit shifters plus the clock counter; clock edges while
    // idle are ignored because the edge detects are gated by the frame state.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_q <= '0;
            tx_q <= '0;
            cnt_q <= '0;
        end else if (csn_fall) begin
            cnt_q <= '0;
        end else if (sclk_rise) begin
            rx_q <= {rx_q[FRAME_BITS-2:0], sin_s};
            if (cnt_q != '1) begin
                cnt_q <= cnt_q + 6'h01;
            end
            if (cnt_q == '0) begin
                tx_q <= {status_byte, readback};
            end
        end else if (sclk_fall && cnt_q != '0) begin
            tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
        end
    end

    // Output pin: released while select is high, fault flag until the first clock.
    // The count still holds the last frame's value on the opening edge of select.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sout_q <= 1'b0;
            sout_oe_n_q <= 1'b1;
        end else if (csn_s) begin
            sout_q <= 1'b0;
            sout_oe_n_q <= 1'b1;
        end else begin
            sout_oe_n_q <= 1'b0;
            sout_q <= (csn_fall || cnt_q == '0) ? global_fault_flag : tx_q[FRAME_BITS-1];
        end
    end

    // Control register; an all-ones frame zeroes it and so drops every driver.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q <= CONTROL_RESET;
        end else if (stuck) begin
            ctrl_q <= CONTROL_RESET;
        end else if (exec && op == OP_WRITE && addr == ADDR_CONTROL) begin
            ctrl_q <= rx_q[DATA_W-1:0] & CONTROL_MASK;
        end
    end

    // Configuration register; the low three bits are not implemented.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_q <= CONFIG_RESET;
        end else if (exec && op == OP_WRITE && addr == ADDR_CONFIG) begin
            cfg_q <= rx_q[DATA_W-1:0] & CONFIG_MASK;
        end
    end

    // Selection for the next readback.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_op_q <= OP_READ;
            sel_addr_q <= ADDR_CONTROL;
        end else if (exec) begin
            sel_op_q <= op;
            sel_addr_q <= addr;
        end
    end

    // Sticky diagnosis; a new event in the clearing cycle survives.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            diag_q <= '0;
            uov_q <= 1'b0;
        end else begin
            diag_q <= (rdclr_hit ? '0 : diag_q) | i_diag_event;
            uov_q <= (rdclr_hit ? 1'b0 : uov_q) | i_supply_fault;
        end
    end

    // Thermal flag cleared by a control write with mode at zero; set wins.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tsd_q <= 1'b0;
        end else if (i_thermal_event) begin
            tsd_q <= 1'b1;
        end else if (exec && op == OP_WRITE && addr == ADDR_CONTROL
                     && !rx_q[CTL_MODE]) begin
            tsd_q <= 1'b0;
        end
    end

    // Transmission error: set by a bad count, cleared by the next good frame.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tf_q <= 1'b0;
            reset_indicator_q <= 1'b0;
            not_ready_flag_q <= 1'b1;
        end else begin
            not_ready_flag_q <= i_not_ready;
            if (frame_bad) begin
                tf_q <= 1'b1;
            end else if (frame_ok) begin
                tf_q <= 1'b0;
            end
            if (frame_ok) begin
                reset_indicator_q <= 1'b1;
            end
        end
    end

    // User side outputs, all registered.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            standby_q <= 1'b1;
            done_q <= 1'b0;
        end else begin
            standby_q <= ~ctrl_q[CTL_MODE];
            done_q <= frame_end;
        end
    end

    assign link.serial_out = sout_q;
    assign link.serial_out_oe_n = sout_oe_n_q;
    assign o_bridge_control = ctrl_q;
    assign o_general_configuration = cfg_q;
    assign o_standby = standby_q;
    assign o_frame_done = done_q;
endmodule : mpspi_device

/* File: rtl/mpspi_host.sv */
`timescale 1ns/10ps
module mpspi_host (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    mpspi_if.host link,
    input wire logic i_start,
    input wire logic i_poll,
    input wire logic [mpspi_pkg::FRAME_BITS-1:0] i_frame,
    output logic o_busy,
    output logic o_done,
    output logic [mpspi_pkg::FRAME_BITS-1:0] o_rx_frame,
    output logic o_fault_flag
);
    import mpspi_pkg::*;

    typedef enum logic [4:0] {
        HST_GAP = 5'b00001,
        HST_IDLE = 5'b00010,
        HST_HIGH = 5'b00100,
        HST_LOW = 5'b01000,
        HST_POLL = 5'b10000
    } mpspi_hst_e;

    mpspi_hst_e state_q;
    logic [1:0] miso_sync_q;
    logic [HALF_W-1:0] half_q;
    logic [GAP_W-1:0] gap_q;
    logic [CNT_W-1:0] bits_q;
    logic [FRAME_BITS-1:0] tx_q;
    logic [FRAME_BITS-1:0] rx_q;
    logic sclk_q;
    logic csn_q;
    logic mosi_q;
    logic done_q;
    logic flt_q;
    logic half_end;

    assign half_end = (half_q == HALF_W'(SCLK_HALF_CYC - 1));

    // Returned data comes from another end, so it is synchronised first.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            miso_sync_q <= 2'h0;
        end else begin
            miso_sync_q <= {miso_sync_q[0], link.serial_out};
        end
    end

    // Half period counter for the divided serial clock.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            half_q <= '0;
        end else if (state_q == HST_IDLE || state_q == HST_GAP || half_end) begin
            half_q <= '0;
        end else begin
            half_q <= half_q + HALF_W'(1);
        end
    end

    // Frame sequencer; clock toggles only while select is low, and a long
    // select-high gap follows each frame so a standby device can wake.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= HST_GAP;
            gap_q <= '0;
            bits_q <= '0;
            sclk_q <= 1'b0;
            csn_q <= 1'b1;
            mosi_q <= 1'b0;
            tx_q <= '0;
            rx_q <= '0;
            done_q <= 1'b0;
            flt_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                HST_GAP: begin
                    gap_q <= gap_q + GAP_W'(1);
                    if (gap_q == GAP_W'(CSN_HIGH_CYC - 1)) begin
                        gap_q <= '0;
                        state_q <= HST_IDLE;
                    end
                end
                HST_IDLE: begin
                    if (i_start) begin
                        csn_q <= 1'b0;
                        tx_q <= {i_frame[FRAME_BITS-2:0], 1'b0};
                        mosi_q <= i_frame[FRAME_BITS-1];
                        bits_q <= '0;
                        state_q <= HST_LOW;
                    end else if (i_poll) begin
                        csn_q <= 1'b0;
                        state_q <= HST_POLL;
                    end
                end
                HST_LOW: begin
                    if (half_end) begin
                        sclk_q <= 1'b1;
                        rx_q <= {rx_q[FRAME_BITS-2:0], miso_sync_q[1]};
                        bits_q <= bits_q + CNT_W'(1);
                        state_q <= HST_HIGH;
                    end
                end
                HST_HIGH: begin
                    if (half_end) begin
                        sclk_q <= 1'b0;
                        if (bits_q == FRAME_COUNT) begin
                            csn_q <= 1'b1;
                            done_q <= 1'b1;
                            state_q <= HST_GAP;
                        end else begin
                            mosi_q <= tx_q[FRAME_BITS-1];
                            tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
                            state_q <= HST_LOW;
                        end
                    end
                end
                HST_POLL: begin
                    if (half_end) begin
                        flt_q <= miso_sync_q[1];
                        csn_q <= 1'b1;
                        done_q <= 1'b1;
                        state_q <= HST_GAP;
                    end
                end
                default: state_q <= HST_GAP;
            endcase
        end
    end

    assign link.serial_clk = sclk_q;
    assign link.select_n = csn_q;
    assign link.serial_in = mosi_q;
    assign o_busy = ~csn_q;
    assign o_done = done_q;
    assign o_rx_frame = rx_q;
    assign o_fault_flag = flt_q;
endmodule : mpspi_host

/* File: bench/mpspi_sva.sv */
`timescale 1ns/10ps
module mpspi_sva (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic serial_clk,
    input wire logic select_n,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe_n
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);
    logic sclk_q;
    logic sel_q;
    logic [5:0] rise_q;
    logic [3:0] quiet_q;

    // Previous pin levels, so edges can be found without design internals.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_q <= 1'b0;
            sel_q <= 1'b1;
        end else begin
            sclk_q <= serial_clk;
            sel_q <= select_n;
        end
    end

    // Rises per frame; saturation keeps a runaway clock from wrapping to a legal count.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rise_q <= 6'h00;
        end else if (sel_q && !select_n) begin
            rise_q <= 6'h00;
        end else if (!sclk_q && serial_clk && rise_q != 6'h3F) begin
            rise_q <= rise_q + 6'h01;
        end
    end

    // Cycles since the last edge on either link control pin.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            quiet_q <= 4'hF;
        end else if (sclk_q != serial_clk || sel_q != select_n) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hF) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end

    sequence s_poll_open;
        $fell(select_n) ##3 (!select_n && !serial_clk) [*6];
    endsequence
    property p_oe_on;
        $fell(select_n) |-> ##[1:6] !serial_out_oe_n;
    endproperty
    property p_oe_hold;
        (!select_n) [*6] |-> !serial_out_oe_n;
    endproperty
    property p_oe_off;
        select_n [*8] |-> serial_out_oe_n;
    endproperty
    property p_oe_release;
        $rose(select_n) |-> ##[1:6] serial_out_oe_n;
    endproperty
    property p_poll_stable;
        s_poll_open |-> serial_out == $past(serial_out, 5);
    endproperty
    property p_shift_after_edge;
        (!select_n && !$stable(serial_out)) |-> quiet_q <= 4'h6;
    endproperty
    property p_clk_in_frame;
        $rose(serial_clk) |-> !select_n;
    endproperty
    property p_sclk_idle;
        select_n [*2] |-> !serial_clk;
    endproperty
    property p_frame_len;
        $rose(select_n) |-> (rise_q == 6'h00 || rise_q == 6'h18);
    endproperty
    property p_sin_stable;
        $rose(serial_clk) |-> $stable(serial_in);
    endproperty

    a_oe_on: assert property (p_oe_on) else $error("output not enabled after select");
    a_oe_hold: assert property (p_oe_hold) else $error("output dropped in frame");
    a_oe_off: assert property (p_oe_off) else $error("output driven while idle");
    a_oe_release: assert property (p_oe_release) else $error("output not released");
    a_poll_stable: assert property (p_poll_stable) else $error("poll value moved");
    a_shift_after_edge: assert property (p_shift_after_edge) else $error("late shift");
    a_clk_in_frame: assert property (p_clk_in_frame) else $error("clock outside frame");
    a_sclk_idle: assert property (p_sclk_idle) else $error("clock not idle low");
    a_frame_len: assert property (p_frame_len) else $error("bad frame length");
    a_sin_stable: assert property (p_sin_stable) else $error("data moved at rise");
endmodule : mpspi_sva

/* File: bench/motor_predriver_spi_slave_tb.sv */
`timescale 1ns/10ps
module motor_predriver_spi_slave_tb;
    import mpspi_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic poll = 1'b0;
    logic therm = 1'b0;
    logic not_ready_flag = 1'b1;
    logic sfault = 1'b0;
    logic [15:0] diag = 16'h0000;
    logic [23:0] frame = 24'h000000;
    logic [23:0] rx_frame;
    logic busy, done, fault, standby, fdone;
    logic [15:0] ctrl, cfg;
    int n_errors = 0;
    int checks = 0;
    mpspi_if link_a ();
    mpspi_if link_b ();
    // The second device sees a bench master that may break framing on purpose.
    wire sout_b = link_b.serial_out_oe_n ? 1'bz : link_b.serial_out;

    // System clock.
    always #2.5 clk_sys = ~clk_sys;

    mpspi_host mpspi_host_inst (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .link(link_a.host),
        .i_start(start), .i_poll(poll), .i_frame(frame), .o_busy(busy), .o_done(done),
        .o_rx_frame(rx_frame), .o_fault_flag(fault));
    mpspi_device mpspi_device_inst (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .link(link_a.dev),
        .i_thermal_event(therm), .i_supply_fault(sfault), .i_not_ready(not_ready_flag),
        .i_diag_event(diag), .o_bridge_control(ctrl), .o_general_configuration(cfg),
        .o_standby(standby), .o_frame_done(fdone));
    mpspi_device mpspi_device_inst_b (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
        .link(link_b.dev), .i_thermal_event(1'b0), .i_supply_fault(1'b0),
        .i_not_ready(1'b0), .i_diag_event(16'h0000), .o_bridge_control(),
        .o_general_configuration(), .o_standby(), .o_frame_done());
    mpspi_sva mpspi_sva_inst (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
        .serial_clk(link_a.serial_clk), .select_n(link_a.select_n),
        .serial_in(link_a.serial_in), .serial_out(link_a.serial_out),
        .serial_out_oe_n(link_a.serial_out_oe_n));

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test;
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // Bounded wait for the host's end-of-transfer pulse; the select gap is left to the caller.
    task automatic wait_done;
        int n;
        n = 0;
        while (done !== 1'b1 && n < 1000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 1000) begin
            n_errors++;
        end
    endtask : wait_done

    task automatic xfer(input logic [23:0] f, input logic [7:0] st, input logic [15:0] d);
        int n;
        frame = f;
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        wait_done;
        chk(busy, 1'b0);
        chk(rx_frame[23:16], st);
        chk(rx_frame[15:0], d);
        n = 0;
        while (fdone !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        chk(fdone, 1'b1);
        repeat (2100) @(negedge clk_sys);
    endtask : xfer

    // Hand-driven master on the second link; edges sit between system clock edges.
    task automatic bb(input int n, input logic [23:0] d, input logic global_fault_flag,
                      output logic [23:0] q);
        q = 24'h000000;
        @(negedge clk_sys);
        #1 link_b.select_n = 1'b0;
        link_b.serial_in = d[23];
        #100 chk(link_b.serial_out_oe_n, 1'b0);
        chk(sout_b, global_fault_flag);
        for (int i = 0; i < n; i++) begin
            #62.5 link_b.serial_clk = 1'b1;
            q = {q[22:0], sout_b};
            #62.5 link_b.serial_clk = 1'b0;
            d = {d[22:0], 1'b0};
            link_b.serial_in = d[23];
        end
        #62.5 link_b.select_n = 1'b1;
        #100 chk(link_b.serial_out_oe_n, 1'b1);
        #10000;
    endtask : bb

    task automatic t_poll;
        poll = 1'b1;
        @(negedge clk_sys);
        poll = 1'b0;
        wait_done;
        chk(fault, 1'b1);
        repeat (2100) @(negedge clk_sys);
    endtask : t_poll

    task automatic t_write_control;
        xfer({OP_WRITE, ADDR_CONTROL, 16'hFFFF}, 8'h81, 16'h0000);
        chk(ctrl, 16'h03DF);
        chk(standby, 1'b0);
    endtask : t_write_control

    task automatic t_thermal_clear;
        not_ready_flag = 1'b0;
        therm = 1'b1;
        @(negedge clk_sys);
        therm = 1'b0;
        xfer({OP_READ, ADDR_CONTROL, 16'h0000}, 8'hB0, 16'h03DF);
        xfer({OP_WRITE, ADDR_CONTROL, 16'h0000}, 8'hB0, 16'h03DF);
        chk(standby, 1'b1);
    endtask : t_thermal_clear

    task automatic t_config_info;
        xfer({OP_WRITE, ADDR_CONFIG, 16'hFFFF}, 8'h20, 16'h0000);
        chk(cfg, 16'hFFF8);
        xfer({OP_INFO, ADDR_FRAME_ID, 16'h0000}, 8'h20, 16'hFFF8);
        diag = 16'h0005;
        sfault = 1'b1;
        @(negedge clk_sys);
        diag = 16'h0000;
        sfault = 1'b0;
        xfer({OP_RDCLR, ADDR_STATUS, 16'h0000}, 8'hA4, 16'h0018);
    endtask : t_config_info

    task automatic t_rdclr_standby;
        xfer({OP_WRITE, ADDR_CONTROL, 16'h0001}, 8'hA4, 16'h0005);
        chk(standby, 1'b0);
        xfer(24'hFFFFFF, 8'h20, 16'h0001);
        chk(ctrl, 16'h0000);
        chk(standby, 1'b1);
    endtask : t_rdclr_standby

    task automatic t_bad_count;
        logic [23:0] q;
        bb(24, {OP_READ, ADDR_CONTROL, 16'h0000}, 1'b1, q);
        chk(q[23:16], 8'h80);
        bb(5, {OP_WRITE, ADDR_CONTROL, 16'h0001}, 1'b0, q);
        bb(24, {OP_READ, ADDR_CONTROL, 16'h0000}, 1'b1, q);
        chk(q[23:16], 8'hE0);
        chk(q[15:0], 16'h0000);
        bb(24, {OP_READ, ADDR_CONTROL, 16'h0000}, 1'b0, q);
        chk(q[23:16], 8'h20);
        bb(0, 24'h000000, 1'b0, q);
        bb(24, {OP_READ, ADDR_CONTROL, 16'h0000}, 1'b0, q);
        chk(q[23:16], 8'h20);
    endtask : t_bad_count

    // Main sequence; the second link idles until its own scenario.
    initial begin
        link_b.select_n = 1'b1;
        link_b.serial_clk = 1'b0;
        link_b.serial_in = 1'b0;
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (2100) @(negedge clk_sys);
        t_poll;
        t_write_control;
        t_thermal_clear;
        t_config_info;
        t_rdclr_standby;
        t_bad_count;
        end_of_test;
    end

    // Watchdog well beyond the expected run of about 200 us.
    initial begin
        #400000;
        n_errors++;
        end_of_test;
    end
endmodule : motor_predriver_spi_slave_tb
